// File: common/asvr_pkg.sv
// Package of constants and types for the ASCII variable string receiver
`default_nettype none
package asvr_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned ASVR_CLK_HZ = 100_000_000;
  localparam int unsigned ASVR_MS_UNIT = 1;
  // Cycles in one millisecond of timeout setting
  localparam int unsigned ASVR_CYC_PER_MS = ASVR_CLK_HZ / 1000 * ASVR_MS_UNIT;
  localparam int unsigned ASVR_MS_CNT_W = 17;
  // ****************************************
  // Sizes and limits
  // ****************************************
  localparam int unsigned ASVR_MAX_LEN_DEF = 128;
  localparam int unsigned ASVR_LEN_W = 8;
  localparam int unsigned ASVR_ADDR_W = 16;
  localparam int unsigned ASVR_TMO_W = 16;
  localparam int unsigned ASVR_WORD_W = 16;
  localparam logic [7:0] ASVR_LEN_MIN = 8'h01;
  localparam logic [7:0] ASVR_LEN_MAX = 8'h80;
  localparam logic [15:0] ASVR_TMO_OFF = 16'h0000;
  // Receiver states
  typedef enum logic [2:0] {
    ASVR_IDLE,
    ASVR_WAIT_FIRST,
    ASVR_RECV,
    ASVR_FLUSH,
    ASVR_DONE,
    ASVR_FAULT
  } asvr_state_t;
endpackage
`default_nettype wire

// File: src/asvr_ms_timer.sv
// Millisecond timer that counts elapsed time since its last restart
`default_nettype none
module asvr_ms_timer
  import asvr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = ASVR_CYC_PER_MS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [ASVR_TMO_W-1:0] limit_ms,
  output logic expired
);
  logic [ASVR_MS_CNT_W-1:0] cyc_q, cyc_d;
  logic [ASVR_TMO_W:0] ms_q, ms_d;
  logic tick;

  // Prescaler and saturating ms counter
  always_comb
  begin
    tick = (cyc_q == ASVR_MS_CNT_W'(CYC_PER_MS - 1));
    cyc_d = tick ? '0 : cyc_q + 1'b1;
    ms_d = ms_q;
    if (tick && !ms_q[ASVR_TMO_W])
    begin
      ms_d = ms_q + 1'b1;
    end
    if (restart)
    begin
      cyc_d = '0;
      ms_d = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cyc_q <= '0;
      ms_q <= '0;
    end
    else
    begin
      cyc_q <= cyc_d;
      ms_q <= ms_d;
    end
  end

  // Exceeds means strictly more whole ms than set; zero disables
  // RL7 zero disables check
  assign expired = (limit_ms != ASVR_TMO_OFF) && (ms_q > {1'b0, limit_ms});
endmodule
`default_nettype wire

// File: src/asvr_receiver.sv
// Variable-length ASCII string receiver writing packed words to memory
// ****************************************
// Functional notes
// RL1: Strings vary in length and end on termination characters, not a count.
// RL2: Each string is stored in word memory starting at the destination address.
// RL3: Maximum length is configured in bytes, valid from 1 to 128.
// RL4: A gap between characters longer than the inter-character timeout sets its flag.
// RL5: After an inter-character timeout no received data is written to memory.
// RL6: The inter-character timeout flag clears only when enable drops.
// RL7: A timeout setting of zero disables that timeout check.
// RL8: Too long a wait from enable to first character sets the first-character flag.
// RL9: The first-character timeout flag holds until enable drops.
// RL10: With byte swap on, the two bytes of every stored word are exchanged.
// RL11: The termination code is one or two characters, as configured.
// RL12: Busy is high while the receiver is taking in data.
// RL13: Complete is set once data through the termination code has arrived.
// RL14: Complete clears when enable drops.
// RL15: Overflow is set when received bytes exceed the maximum length.
// RL16: Bytes pack two per word in arrival order, low byte first unless swapped.
// RL17: A new reception needs enable dropped and raised again.
// ****************************************
`default_nettype none
module asvr_receiver
  import asvr_pkg::*;
#(
  parameter int unsigned MAX_LEN = ASVR_MAX_LEN_DEF,
  parameter int unsigned CYC_PER_MS = ASVR_CYC_PER_MS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_enable,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic [ASVR_ADDR_W-1:0] dest_addr,
  input wire logic [ASVR_LEN_W-1:0] max_len,
  input wire logic [ASVR_TMO_W-1:0] interchar_tmo_ms,
  input wire logic [ASVR_TMO_W-1:0] firstchar_tmo_ms,
  input wire logic byte_swap,
  input wire logic term_two,
  input wire logic [7:0] term_char0,
  input wire logic [7:0] term_char1,
  output logic mem_we,
  output logic [ASVR_ADDR_W-1:0] mem_addr,
  output logic [ASVR_WORD_W-1:0] mem_wdata,
  output logic busy,
  output logic complete,
  output logic interchar_err,
  output logic firstchar_err,
  output logic overflow_err,
  output logic cfg_err
);
  // One spare slot: a first terminator char may land right at the length limit
  localparam int unsigned BUF_N = MAX_LEN + 1;

  // ****************************************
  // State
  // ****************************************
  asvr_state_t state_q, state_d;
  logic [7:0] buf_q [BUF_N];
  logic [ASVR_LEN_W-1:0] cnt_q, cnt_d;
  logic [ASVR_LEN_W-1:0] rd_q, rd_d;
  logic [7:0] prev_q, prev_d;
  logic en_q, en_d;
  logic done_q, done_d, ic_q, ic_d, fc_q, fc_d, ov_q, ov_d, ce_q, ce_d;
  logic we_q, we_d;
  logic [ASVR_ADDR_W-1:0] addr_q, addr_d;
  logic [ASVR_WORD_W-1:0] wdata_q, wdata_d;
  logic restart, ic_exp, fc_exp, is_term, buf_we;
  logic [7:0] lo_b, hi_b;

  // Shared timer; restarted on enable rise and on every character
  asvr_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .restart(restart),
    .limit_ms(state_q == ASVR_WAIT_FIRST ? firstchar_tmo_ms : interchar_tmo_ms),
    .expired(ic_exp)
  );
  assign fc_exp = ic_exp;

  // Termination match on one or two characters
  always_comb
  begin
    // RL11 term code match
    if (term_two)
    begin
      is_term = (cnt_q != '0) && (prev_q == term_char0) && (rx_data == term_char1);
    end
    else
    begin
      is_term = (rx_data == term_char0);
    end
  end

  // Next-state logic for the whole receive sequence
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    prev_d = prev_q;
    en_d = rx_enable;
    done_d = done_q;
    ic_d = ic_q;
    fc_d = fc_q;
    ov_d = ov_q;
    ce_d = ce_q;
    we_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    restart = 1'b0;
    buf_we = 1'b0;
    lo_b = buf_q[rd_q];
    hi_b = (rd_q + 1'b1 < cnt_q) ? buf_q[ASVR_LEN_W'(rd_q + 1'b1)] : 8'h00;
    case (state_q)
      ASVR_IDLE:
      begin
        // RL17 rising edge arms
        if (rx_enable && !en_q)
        begin
          restart = 1'b1;
          cnt_d = '0;
          rd_d = '0;
          // RL3 length range check
          if (max_len < ASVR_LEN_MIN || max_len > ASVR_LEN_MAX
              || 32'(max_len) > MAX_LEN)
          begin
            ce_d = 1'b1;
            state_d = ASVR_FAULT;
          end
          else
          begin
            state_d = ASVR_WAIT_FIRST;
          end
        end
      end
      ASVR_WAIT_FIRST, ASVR_RECV:
      begin
        if (rx_valid)
        begin
          restart = 1'b1;
          prev_d = rx_data;
          state_d = ASVR_RECV;
          // RL1 end on terminator
          if (is_term)
          begin
            // Strip the first terminator already buffered in two-char mode
            if (term_two)
            begin
              cnt_d = cnt_q - 1'b1;
            end
            rd_d = '0;
            addr_d = dest_addr;
            state_d = ASVR_FLUSH;
          end
          // RL15 overflow on excess
          // Only one pending first terminator may pass the limit, never a run of them
          else if (cnt_q > max_len
                   || (cnt_q == max_len && !(term_two && rx_data == term_char0)))
          begin
            ov_d = 1'b1;
            state_d = ASVR_FAULT;
          end
          else
          begin
            buf_we = 1'b1;
            cnt_d = cnt_q + 1'b1;
          end
        end
        // RL8 first char timeout
        else if (state_q == ASVR_WAIT_FIRST && fc_exp)
        begin
          fc_d = 1'b1;
          state_d = ASVR_FAULT;
        end
        // RL4 interchar timeout
        else if (state_q == ASVR_RECV && ic_exp)
        begin
          // RL5 nothing stored
          ic_d = 1'b1;
          state_d = ASVR_FAULT;
        end
      end
      ASVR_FLUSH:
      begin
        // RL2 write from destination
        if (rd_q < cnt_q)
        begin
          we_d = 1'b1;
          addr_d = (rd_q == '0) ? dest_addr : addr_q + 1'b1;
          // RL16 low byte first
          wdata_d = {hi_b, lo_b};
          // RL10 byte swap
          if (byte_swap)
          begin
            wdata_d = {lo_b, hi_b};
          end
          rd_d = rd_q + 2'd2;
        end
        else
        begin
          // RL13 complete after terminator
          done_d = 1'b1;
          state_d = ASVR_DONE;
        end
      end
      default:
      begin
        state_d = state_q;
      end
    endcase
    // RL6 RL9 RL14 flags cleared on enable drop
    if (!rx_enable)
    begin
      state_d = ASVR_IDLE;
      done_d = 1'b0;
      ic_d = 1'b0;
      fc_d = 1'b0;
      ov_d = 1'b0;
      ce_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ASVR_IDLE;
      cnt_q <= '0;
      rd_q <= '0;
      prev_q <= 8'h00;
      en_q <= 1'b0;
      done_q <= 1'b0;
      ic_q <= 1'b0;
      fc_q <= 1'b0;
      ov_q <= 1'b0;
      ce_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      prev_q <= prev_d;
      en_q <= en_d;
      done_q <= done_d;
      ic_q <= ic_d;
      fc_q <= fc_d;
      ov_q <= ov_d;
      ce_q <= ce_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // String staging buffer; held back from memory so a timeout discards it
  always_ff @(posedge mclk)
  begin
    if (buf_we)
    begin
      buf_q[cnt_q] <= rx_data;
    end
  end

  assign mem_we = we_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  // RL12 busy while receiving
  assign busy = (state_q == ASVR_WAIT_FIRST) || (state_q == ASVR_RECV)
              || (state_q == ASVR_FLUSH);
  assign complete = done_q;
  assign interchar_err = ic_q;
  assign firstchar_err = fc_q;
  assign overflow_err = ov_q;
  assign cfg_err = ce_q;
endmodule
`default_nettype wire

// File: bench/asvr_receiver_sva.sv
// Port checker for the string receiver
`default_nettype none
module asvr_receiver_sva
  import asvr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_enable,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic [ASVR_ADDR_W-1:0] dest_addr,
  input wire logic term_two,
  input wire logic [7:0] term_char0,
  input wire logic mem_we,
  input wire logic [ASVR_ADDR_W-1:0] mem_addr,
  input wire logic busy,
  input wire logic complete,
  input wire logic interchar_err,
  input wire logic firstchar_err,
  input wire logic overflow_err,
  input wire logic [ASVR_LEN_W-1:0] max_len,
  input wire logic cfg_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Enable low two cycles, then raised
  sequence s_arm;
    !rx_enable ##1 !rx_enable ##1 rx_enable;
  endsequence
  // Arm with a length setting inside the legal range
  sequence s_arm_ok;
    s_arm ##0 (max_len >= ASVR_LEN_MIN && max_len <= ASVR_LEN_MAX);
  endsequence
  // Arm with a zero length setting
  sequence s_arm_bad;
    s_arm ##0 (max_len == 8'h00);
  endsequence
  // Lone terminator taken with no fault pending
  sequence s_term;
    busy && rx_valid && !term_two && rx_data == term_char0 && !overflow_err && !interchar_err;
  endsequence
  a_busy_on_arm: assert property (s_arm_ok |=> busy)
    else $error("busy missing after enable");
  a_cfg_refuse: assert property (s_arm_bad |=> cfg_err && !busy)
    else $error("bad length not refused");
  // Worst case is 64 words plus two cycles
  a_term_done: assert property (s_term |-> ##[2:70] complete)
    else $error("complete late after terminator");
  a_flags_clear: assert property (!rx_enable |=> !complete && !interchar_err
    && !firstchar_err && !overflow_err)
    else $error("flag kept after enable low");
  a_icto_hold: assert property (interchar_err && rx_enable |=> interchar_err)
    else $error("interchar flag dropped");
  a_fcto_hold: assert property (firstchar_err && rx_enable |=> $stable(firstchar_err))
    else $error("firstchar flag dropped");
  a_cmp_hold: assert property (complete && rx_enable |=> complete)
    else $error("complete dropped");
  a_tmo_nowrite: assert property (interchar_err |-> !mem_we)
    else $error("write after timeout");
  a_ovf_nowrite: assert property (overflow_err |-> !mem_we)
    else $error("write after overflow");
  a_first_addr: assert property ($rose(mem_we) |-> mem_addr == dest_addr)
    else $error("first word off destination");
  a_done_idle: assert property (complete |-> !busy)
    else $error("busy with complete");
endmodule
bind asvr_receiver asvr_receiver_sva i_asvr_receiver_sva (.mclk(mclk), .rst(rst),
  .rx_enable(rx_enable), .rx_valid(rx_valid), .rx_data(rx_data), .dest_addr(dest_addr),
  .term_two(term_two), .term_char0(term_char0), .mem_we(mem_we), .mem_addr(mem_addr),
  .busy(busy), .complete(complete), .interchar_err(interchar_err),
  .firstchar_err(firstchar_err), .overflow_err(overflow_err), .max_len(max_len),
  .cfg_err(cfg_err));
`default_nettype wire

// File: bench/asvr_src.sv
// Serial ASCII source model feeding the receiver
`default_nettype none
module asvr_src
(
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // One pulse a byte; data shows the inverse after, so stale bytes never match
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    #1;
    rx_valid = 1'b1;
    rx_data = b;
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      send(s[i]);
    end
  endtask
endmodule
`default_nettype wire

// File: bench/asvr_receiver_tb_top.sv
// Self-checking bench for the string receiver
`default_nettype none
module asvr_receiver_tb_top
  import asvr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, rx_enable, rx_valid, byte_swap, term_two;
  logic [7:0] rx_data, max_len;
  logic [15:0] dest_addr, ict, fct, mem_addr, mem_wdata;
  logic mem_we, busy, complete, ic_err, fc_err, ov_err, cfg_err;
  logic [31:0] wq[$];
  int num_errors = 0;
  int n_tests = 0;
  asvr_receiver #(.CYC_PER_MS(10)) i_asvr_receiver (.mclk(mclk), .rst(rst),
    .rx_enable(rx_enable), .rx_valid(rx_valid), .rx_data(rx_data), .dest_addr(dest_addr),
    .max_len(max_len), .interchar_tmo_ms(ict), .firstchar_tmo_ms(fct), .byte_swap(byte_swap),
    .term_two(term_two), .term_char0(8'h0D), .term_char1(8'h0A), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .complete(complete),
    .interchar_err(ic_err), .firstchar_err(fc_err), .overflow_err(ov_err), .cfg_err(cfg_err));
  asvr_src i_asvr_src (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Log every word written
  always @(posedge mclk)
  begin
    if (mem_we === 1'b1)
      wq.push_back({mem_addr, mem_wdata});
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Expected words from the payload; odd tail pairs with zero
  task automatic chk_str(input string s);
    logic [7:0] lo, hi;
    chk("words", 16'((s.len() + 1) / 2), 16'(wq.size()));
    for (int i = 0; i < (s.len() + 1) / 2 && i < wq.size(); i++)
    begin
      lo = s[2 * i];
      hi = (2 * i + 1 < s.len()) ? s[2 * i + 1] : 8'h00;
      chk("addr", dest_addr + 16'(i), wq[i][31:16]);
      chk("data", byte_swap ? {lo, hi} : {hi, lo}, wq[i][15:0]);
    end
  endtask
  // Rearm needs enable dropped first
  // rearm by enable
  task automatic arm;
    @(posedge mclk);
    #1 rx_enable = 1'b0;
    wq.delete();
    repeat (2) @(posedge mclk);
    #1 rx_enable = 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic drop;
    @(posedge mclk);
    #1 rx_enable = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("flags", 16'h0000, {complete, ic_err, fc_err, ov_err});
  endtask
  task automatic finish_str(input string s);
    for (int k = 0; k < 40 && complete !== 1'b1; k++)
      @(posedge mclk);
    #1 chk("complete", 16'h0001, complete);
    chk("busy", 16'h0000, busy);
    chk_str(s);
  endtask
  task automatic t_basic;
    arm();
    i_asvr_src.send_str("ABC\015");
    finish_str("ABC");
    $display("t_basic done");
  endtask
  task automatic t_swap2;
    byte_swap = 1'b1;
    term_two = 1'b1;
    arm();
    i_asvr_src.send_str("A\015B\015\012");
    finish_str("A\015B");
    byte_swap = 1'b0;
    term_two = 1'b0;
    $display("t_swap2 done");
  endtask
  task automatic t_ovf;
    max_len = 8'h02;
    arm();
    i_asvr_src.send_str("AB\015");
    finish_str("AB");
    arm();
    i_asvr_src.send_str("ABC");
    repeat (5) @(posedge mclk);
    #1 chk("overflow", 16'h0001, ov_err);
    chk_str("");
    drop();
    // A zero length setting is refused and nothing starts
    max_len = 8'h00;
    arm();
    #1 chk("cfg_err", 16'h0001, cfg_err);
    chk("busy", 16'h0000, busy);
    drop();
    chk("cfg_err", 16'h0000, cfg_err);
    max_len = 8'h80;
    $display("t_ovf done");
  endtask
  task automatic t_tmo;
    ict = 16'h0001;
    arm();
    i_asvr_src.send("A");
    repeat (40) @(posedge mclk);
    i_asvr_src.send(8'h0D);
    repeat (8) @(posedge mclk);
    #1 chk("ic_err", 16'h0001, ic_err);
    chk_str("");
    drop();
    ict = 16'h0000;
    fct = 16'h0001;
    arm();
    repeat (40) @(posedge mclk);
    #1 chk("fc_err", 16'h0001, fc_err);
    drop();
    // A zero first-char setting must tolerate a long wait for the first char
    fct = 16'h0000;
    arm();
    repeat (60) @(posedge mclk);
    i_asvr_src.send_str("Z\015");
    finish_str("Z");
    chk("errs", 16'h0000, {ic_err, fc_err});
    $display("t_tmo done");
  endtask
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    {rst, rx_enable, byte_swap, term_two} = 4'h8;
    {max_len, dest_addr, ict, fct} = {8'h80, 16'h0120, 32'h0000_0000};
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    t_basic();
    t_swap2();
    t_ovf();
    t_tmo();
    end_sim();
  end
  // Whole run is near 270 cycles
  initial
  begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
